//--- verilog/scs_channel.sv
// One serial channel's external/status enables, line status and special receive status, as an Avalon-MM slave.
// Assumes receiver, transmitter and baud generator strobes come from logic on core_clk; modem and sync pins are async.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "scs_defines.svh"

module scs_channel #(
   parameter int FIFO_DEPTH = 3
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cts_n,
   input wire logic dcd_n,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe_n,
   input wire logic rx_bit_strobe,
   input wire logic rx_bit,
   input wire logic rx_char_strobe,
   input wire logic [7:0] rx_char,
   input wire logic rx_parity_bit,
   input wire logic rx_framing_error,
   input wire logic rx_crc_error,
   input wire logic rx_end_of_frame,
   input wire logic [3:0] rx_last_bits,
   input wire logic rx_break_end,
   input wire logic rx_sync_detect,
   output logic rx_half_bit_extend,
   input wire logic tx_underrun,
   input wire logic tx_crc_sending,
   input wire logic tx_data_take,
   output logic [7:0] tx_data,
   output logic tx_data_valid,
   input wire logic baud_zero,
   output logic ext_status_int,
   output logic rx_special_condition
);

   // ************************************************
   // State.
   // ************************************************
   typedef struct packed {
      logic ack;
      logic wreq;
      logic [31:0] rdata;
      logic [7:0] ie;
      logic [`SCS_MODE_WIDTH-1:0] mode;
      logic [7:0] tx_buf;
      logic tx_full;
      logic brk;
      logic [2:0] ones;
      logic underrun;
      logic hunt;
      logic l_cts;
      logic l_dcd;
      logic l_sync;
      logic pend;
      logic defer;
      logic zc;
      logic crc_fr;
      logic ovr;
      logic par;
      logic eof;
      logic [2:0] residue;
      logic spec;
      logic half_ext;
      logic sync_release;
      logic sync_level;
   } scs_state_type;

   scs_state_type st;
   scs_state_type next_st;

   logic cts_s;
   logic dcd_s;
   logic sync_s;
   scs_pkg::scs_rx_entry_type fifo_head;
   scs_pkg::scs_rx_entry_type push_entry;
   logic fifo_not_empty;
   logic fifo_push;
   logic fifo_pop;
   logic fifo_clear;

   scs_sync2 #(.RESET_VALUE(1'b1)) u_sync_cts (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin(cts_n),
      .level(cts_s)
   );

   scs_sync2 #(.RESET_VALUE(1'b1)) u_sync_dcd (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin(dcd_n),
      .level(dcd_s)
   );

   scs_sync2 #(.RESET_VALUE(1'b1)) u_sync_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin(sync_in),
      .level(sync_s)
   );

   scs_rx_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .clear(fifo_clear),
      .push(fifo_push),
      .push_entry(push_entry),
      .pop(fifo_pop),
      .head(fifo_head),
      .not_empty(fifo_not_empty)
   );

   // ************************************************
   // Residue lookup.
   // ************************************************
   function automatic logic [2:0] residue_code(input logic [3:0] bits);
      case (bits)
         4'h3: residue_code = 3'h4;
         4'h4: residue_code = 3'h2;
         4'h5: residue_code = 3'h6;
         4'h6: residue_code = 3'h1;
         4'h7: residue_code = 3'h5;
         default: residue_code = `SCS_RESIDUE_NONE;
      endcase
   endfunction : residue_code

   // ************************************************
   // Next state.
   // ************************************************
   scs_pkg::scs_mode_type mode;
   logic is_async;
   logic is_sdlc;
   logic is_bisync;
   logic crystal_oscillator_option_async;
   logic do_wr;
   logic do_rd;
   logic [2:0] cmd;
   logic [31:0] rd_mux;
   logic cts_live;
   logic dcd_live;
   logic sync_live;
   logic [7:0] line_status;
   logic [7:0] rx_status;
   logic tbe;
   logic latched_change;
   logic event_now;
   logic parity_bad;
   logic spec_now;

   always_comb begin
      mode = scs_pkg::scs_mode_type'(st.mode[`SCS_MODE_MSB:`SCS_MODE_LSB]);
      is_async = (mode == scs_pkg::SCS_ASYNC);
      is_sdlc = (mode == scs_pkg::SCS_SDLC);
      is_bisync = (mode == scs_pkg::SCS_MONOSYNC) || (mode == scs_pkg::SCS_BISYNC);
      crystal_oscillator_option_async = is_async && st.mode[`SCS_MODE_CRYSTAL_OSCILLATOR_OPTION];
      do_wr = avs_write && st.ack;
      do_rd = avs_read && st.ack;
      cmd = (do_wr && avs_address == `SCS_IDX_COMMAND) ? avs_writedata[2:0] : 3'h0;

      // Live sources: modem pins are active low; sync/hunt source depends on mode.
      cts_live = ~cts_s;
      dcd_live = ~dcd_s;
      if (crystal_oscillator_option_async) begin
         sync_live = 1'b0;
      end else if (is_async || mode == scs_pkg::SCS_EXTSYNC) begin
         sync_live = ~sync_s;
      end else begin
         sync_live = st.hunt;
      end

      tbe = !st.tx_full && !(tx_crc_sending && !is_async);
      line_status[7] = st.brk;
      line_status[6] = st.underrun;
      line_status[5] = st.ie[`SCS_IE_CTS] ? st.l_cts : cts_live;
      line_status[4] = st.ie[`SCS_IE_SYNC] ? st.l_sync : sync_live;
      line_status[3] = st.ie[`SCS_IE_DCD] ? st.l_dcd : dcd_live;
      line_status[2] = tbe;
      line_status[1] = st.zc && st.ie[`SCS_IE_ZERO];
      line_status[0] = fifo_not_empty;
      rx_status = {st.eof, st.crc_fr, st.ovr, st.par, st.residue, 1'b0};
      spec_now = st.spec || (fifo_not_empty && (fifo_head.overrun ||
                 (fifo_head.parity && st.mode[`SCS_MODE_PAR_SPECIAL])));

      case (avs_address)
         `SCS_IDX_LINE_STATUS: rd_mux = {24'h0, line_status};
         `SCS_IDX_RX_STATUS: rd_mux = {24'h0, rx_status};
         `SCS_IDX_IRQ_ENABLE: rd_mux = {24'h0, st.ie};
         `SCS_IDX_MODE: rd_mux = {23'h0, st.mode};
         `SCS_IDX_RX_DATA: rd_mux = {23'h0, spec_now, fifo_head.data};
         `SCS_IDX_PENDING: rd_mux = {31'h0, st.pend};
         default: rd_mux = 32'h0;
      endcase

      next_st = st;

      // Avalon slave: one wait cycle, effects at the edge where waitrequest is low.
      next_st.ack = 1'b0;
      next_st.wreq = 1'b1;
      if ((avs_read || avs_write) && !st.ack) begin
         next_st.ack = 1'b1;
         next_st.wreq = 1'b0;
         next_st.rdata = avs_read ? rd_mux : 32'h0;
      end
      if (do_wr && avs_address == `SCS_IDX_IRQ_ENABLE) begin
         next_st.ie = avs_writedata[7:0] & `SCS_IE_MASK;
      end
      if (do_wr && avs_address == `SCS_IDX_MODE) begin
         next_st.mode = avs_writedata[`SCS_MODE_WIDTH-1:0];
      end

      // Transmit buffer.
      if (tx_data_take) begin
         next_st.tx_full = 1'b0;
      end
      if (do_wr && avs_address == `SCS_IDX_TX_DATA) begin
         next_st.tx_buf = avs_writedata[7:0];
         next_st.tx_full = 1'b1;
      end

      // Break and abort detection.
      next_st.half_ext = 1'b0;
      fifo_push = 1'b0;
      parity_bad = (^{rx_char, rx_parity_bit}) != st.mode[`SCS_MODE_PAR_ODD];
      push_entry.data = rx_char;
      push_entry.overrun = 1'b0;
      push_entry.frame_crc = is_async ? rx_framing_error : rx_crc_error;
      push_entry.parity = st.mode[`SCS_MODE_PAR_EN] && parity_bad;
      push_entry.eof = is_sdlc && rx_end_of_frame;
      push_entry.residue = is_sdlc ? residue_code(rx_last_bits) : `SCS_RESIDUE_NONE;
      if (is_async) begin
         if (rx_break_end) begin
            next_st.brk = 1'b0;
         end
         if (rx_char_strobe) begin
            next_st.half_ext = rx_framing_error;
            if (rx_char == 8'h00 && rx_framing_error && !st.brk) begin
               next_st.brk = 1'b1;
               fifo_push = 1'b1;
            end else if (!st.brk) begin
               fifo_push = 1'b1;
            end
         end
      end else begin
         fifo_push = rx_char_strobe;
         if (is_sdlc && rx_bit_strobe) begin
            if (!rx_bit) begin
               next_st.ones = 3'h0;
               next_st.brk = 1'b0;
            end else if (st.ones != `SCS_ABORT_ONES) begin
               next_st.ones = st.ones + 3'h1;
               next_st.brk = (st.ones + 3'h1) == `SCS_ABORT_ONES;
            end
         end
         if (!is_sdlc) begin
            next_st.brk = 1'b0;
            next_st.ones = 3'h0;
         end
      end

      // Hunt bit and sync pin direction.
      if (cmd == `SCS_CMD_ENTER_HUNT && !is_async) begin
         next_st.hunt = 1'b1;
      end
      if (is_sdlc && st.mode[`SCS_MODE_RX_EN] == 1'b0 && st.hunt == 1'b0) begin
         next_st.hunt = 1'b1;
      end
      if ((is_bisync || is_sdlc) && rx_sync_detect && st.mode[`SCS_MODE_RX_EN]) begin
         next_st.hunt = 1'b0;
      end
      next_st.sync_release = !is_bisync;
      next_st.sync_level = !(is_bisync && rx_sync_detect);

      // Underrun/end-of-message latch.
      if (cmd == `SCS_CMD_RESET_UNDERRUN) begin
         next_st.underrun = 1'b0;
      end
      if (tx_underrun || cmd == `SCS_CMD_SEND_ABORT ||
          (st.mode[`SCS_MODE_TX_EN] && do_wr && avs_address == `SCS_IDX_MODE &&
           !avs_writedata[`SCS_MODE_TX_EN])) begin
         next_st.underrun = 1'b1;
      end

      // External/status pending and latches.
      if (cmd == `SCS_CMD_RESET_EXT) begin
         next_st.pend = st.defer;
         next_st.defer = 1'b0;
         next_st.zc = 1'b0;
      end
      latched_change = (st.ie[`SCS_IE_CTS] && cts_live != st.l_cts) ||
                       (st.ie[`SCS_IE_DCD] && dcd_live != st.l_dcd) ||
                       (st.ie[`SCS_IE_SYNC] && sync_live != st.l_sync);
      if (!st.pend) begin
         next_st.l_cts = cts_live;
         next_st.l_dcd = dcd_live;
         next_st.l_sync = sync_live;
         if (latched_change) begin
            next_st.pend = 1'b1;
         end
      end
      if (baud_zero && st.ie[`SCS_IE_ZERO]) begin
         next_st.zc = 1'b1;
      end
      if (!st.ie[`SCS_IE_ZERO]) begin
         next_st.zc = 1'b0;
      end
      event_now = (st.ie[`SCS_IE_BREAK] && next_st.brk != st.brk) ||
                  (st.ie[`SCS_IE_UNDERRUN] && next_st.underrun && !st.underrun) ||
                  (st.ie[`SCS_IE_ZERO] && baud_zero);
      if (event_now) begin
         if (next_st.pend) begin
            next_st.defer = 1'b1;
         end else begin
            next_st.pend = 1'b1;
         end
      end

      // Special receive status on reading a character.
      fifo_pop = do_rd && avs_address == `SCS_IDX_RX_DATA && fifo_not_empty;
      if (cmd == `SCS_CMD_ERROR_RESET) begin
         next_st.ovr = 1'b0;
         next_st.par = 1'b0;
         next_st.crc_fr = 1'b0;
         next_st.eof = 1'b0;
         next_st.spec = 1'b0;
      end
      if (fifo_pop) begin
         next_st.crc_fr = fifo_head.frame_crc;
         next_st.ovr = next_st.ovr || fifo_head.overrun;
         next_st.par = next_st.par || fifo_head.parity;
         next_st.eof = fifo_head.eof;
         next_st.residue = fifo_head.residue;
         next_st.spec = next_st.spec || fifo_head.overrun ||
                        (fifo_head.parity && st.mode[`SCS_MODE_PAR_SPECIAL]);
      end
      if (!is_sdlc) begin
         next_st.eof = 1'b0;
      end
      if (is_async) begin
         next_st.residue = `SCS_RESIDUE_NONE;
      end

      // Channel reset.
      fifo_clear = (cmd == `SCS_CMD_CHANNEL_RESET);
      if (cmd == `SCS_CMD_CHANNEL_RESET) begin
         next_st.ie = `SCS_IE_RESET;
         next_st.underrun = 1'b1;
         next_st.tx_full = 1'b0;
         next_st.residue = `SCS_RESIDUE_NONE;
         next_st.hunt = 1'b1;
         next_st.brk = 1'b0;
         next_st.ones = 3'h0;
         next_st.zc = 1'b0;
         next_st.pend = 1'b0;
         next_st.defer = 1'b0;
         next_st.ovr = 1'b0;
         next_st.par = 1'b0;
         next_st.crc_fr = 1'b0;
         next_st.eof = 1'b0;
         next_st.spec = 1'b0;
      end
   end

   // ************************************************
   // Registers.
   // ************************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st <= '0;
         st.wreq <= 1'b1;
         st.ie <= `SCS_IE_RESET;
         st.underrun <= 1'b1;
         st.hunt <= 1'b1;
         st.residue <= `SCS_RESIDUE_NONE;
         st.sync_release <= 1'b1;
         st.sync_level <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata = st.rdata;
   assign avs_waitrequest = st.wreq;
   assign sync_out = st.sync_level;
   assign sync_oe_n = st.sync_release;
   assign rx_half_bit_extend = st.half_ext;
   assign tx_data = st.tx_buf;
   assign tx_data_valid = st.tx_full;
   assign ext_status_int = st.pend;
   assign rx_special_condition = st.spec;

endmodule : scs_channel

//--- pkg/scs_defines.svh
// Constants for the serial channel status block: register indices, field positions, reset values, command codes.
// Assumes nothing beyond a SystemVerilog compiler; included by its bare name.
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// ************************************************
// Register word indices (byte address is four times the index).
// ************************************************
`define SCS_IDX_LINE_STATUS 3'h0
`define SCS_IDX_RX_STATUS 3'h1
`define SCS_IDX_IRQ_ENABLE 3'h2
`define SCS_IDX_COMMAND 3'h3
`define SCS_IDX_MODE 3'h4
`define SCS_IDX_RX_DATA 3'h5
`define SCS_IDX_TX_DATA 3'h6
`define SCS_IDX_PENDING 3'h7

// ************************************************
// Enable register fields and reset value.
// ************************************************
`define SCS_IE_BREAK 7
`define SCS_IE_UNDERRUN 6
`define SCS_IE_CTS 5
`define SCS_IE_SYNC 4
`define SCS_IE_DCD 3
`define SCS_IE_ZERO 2
`define SCS_IE_RESET 8'hf8
`define SCS_IE_MASK 8'hfc

// ************************************************
// Mode register fields.
// ************************************************
`define SCS_MODE_LSB 0
`define SCS_MODE_MSB 2
`define SCS_MODE_CRYSTAL_OSCILLATOR_OPTION 3
`define SCS_MODE_TX_EN 4
`define SCS_MODE_RX_EN 5
`define SCS_MODE_PAR_EN 6
`define SCS_MODE_PAR_ODD 7
`define SCS_MODE_PAR_SPECIAL 8
`define SCS_MODE_WIDTH 9

// ************************************************
// Command codes written to the command register.
// ************************************************
`define SCS_CMD_RESET_EXT 3'h1
`define SCS_CMD_ERROR_RESET 3'h2
`define SCS_CMD_ENTER_HUNT 3'h3
`define SCS_CMD_RESET_UNDERRUN 3'h4
`define SCS_CMD_SEND_ABORT 3'h5
`define SCS_CMD_CHANNEL_RESET 3'h6

// ************************************************
// Misc constants.
// ************************************************
`define SCS_RESIDUE_NONE 3'h3
`define SCS_ABORT_ONES 3'h7
`define SCS_VECTOR_BIT 8

`endif

//--- pkg/scs_pkg.sv
// Types shared by the serial channel status block.
// Assumes the constants header is available on the include path.
package scs_pkg;

   typedef enum logic [2:0] {
      SCS_ASYNC = 3'b000,
      SCS_MONOSYNC = 3'b001,
      SCS_BISYNC = 3'b010,
      SCS_SDLC = 3'b011,
      SCS_EXTSYNC = 3'b100
   } scs_mode_type;

   typedef struct packed {
      logic [7:0] data;
      logic overrun;
      logic frame_crc;
      logic parity;
      logic eof;
      logic [2:0] residue;
   } scs_rx_entry_type;

endpackage : scs_pkg

//--- verilog/scs_sync2.sv
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to core_clk; rstn is synchronous, active low.
`timescale 1ns/1ps

module scs_sync2 #(
   parameter logic RESET_VALUE = 1'b1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic pin,
   output logic level
);

   typedef struct packed {
      logic meta;
      logic stable;
   } scs_sync_state_type;

   scs_sync_state_type st;
   scs_sync_state_type next_st;

   always_comb begin
      next_st.meta = pin;
      next_st.stable = st.meta;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st.meta <= RESET_VALUE;
         st.stable <= RESET_VALUE;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.stable;

endmodule : scs_sync2

//--- verilog/scs_rx_fifo.sv
// Receive FIFO holding characters with their per-character error status.
// Assumes push and pop come from logic on core_clk; a push into a full FIFO overwrites the newest entry.
`timescale 1ns/1ps

module scs_rx_fifo #(
   parameter int DEPTH = 3
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clear,
   input wire logic push,
   input wire scs_pkg::scs_rx_entry_type push_entry,
   input wire logic pop,
   output scs_pkg::scs_rx_entry_type head,
   output logic not_empty
);

   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   typedef struct packed {
      scs_pkg::scs_rx_entry_type [DEPTH-1:0] slot;
      logic [CW-1:0] count;
   } scs_fifo_state_type;

   scs_fifo_state_type st;
   scs_fifo_state_type next_st;

   always_comb begin
      next_st = st;
      if (pop && st.count != '0) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_st.slot[i] = st.slot[i + 1];
         end
         next_st.count = st.count - 1'b1;
      end
      if (push) begin
         if (next_st.count == FULL) begin
            // Only the new character that replaces the newest entry is marked as overrun.
            next_st.slot[DEPTH - 1] = push_entry;
            next_st.slot[DEPTH - 1].overrun = 1'b1;
         end else begin
            next_st.slot[next_st.count] = push_entry;
            next_st.count = next_st.count + 1'b1;
         end
      end
      if (clear) begin
         next_st.count = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign head = st.slot[0];
   assign not_empty = (st.count != '0);

endmodule : scs_rx_fifo

//--- tb/scs_line_model.sv
// Far-side model: modem clear-to-send pin and external sync logic.
// Assumes the testbench commands it; the sync pin has a pull-up.
`timescale 1ns/1ps
module scs_line_model (
   input wire logic core_clk,
   input wire logic cts_on,
   input wire logic sync_go,
   input wire logic rx_bit_strobe,
   input wire logic sync_out,
   input wire logic sync_oe_n,
   output logic cts_n,
   output logic sync_in
);
   // ************************************************
   // Sync pin held high until told, low on second bit edge.
   // ************************************************
   logic [1:0] edges;
   logic ext_low;
   always_ff @(posedge core_clk) begin
      if (!sync_go) begin
         edges <= 2'h0;
         ext_low <= 1'b0;
      end else if (rx_bit_strobe && !ext_low) begin
         edges <= edges + 2'h1;
         ext_low <= (edges == 2'h1);
      end
   end
   assign cts_n = !cts_on;
   assign sync_in = sync_oe_n ? !ext_low : sync_out;
endmodule : scs_line_model

//--- tb/scs_checker.sv
// Port checker for the serial channel status block.
// Assumes it is bound to scs_channel and sees only its ports.
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic cts_n,
   input wire logic sync_out,
   input wire logic sync_oe_n,
   input wire logic rx_char_strobe,
   input wire logic rx_framing_error,
   input wire logic rx_sync_detect,
   input wire logic rx_half_bit_extend,
   input wire logic tx_data_take,
   input wire logic tx_data_valid,
   input wire logic baud_zero,
   input wire logic ext_status_int,
   input wire logic rx_special_condition
);
   // ************************************************
   // Enable shadow and assertions.
   // ************************************************
   logic [7:0] ie;
   logic wd;
   logic rd;
   assign wd = avs_write && !avs_waitrequest;
   assign rd = avs_read && !avs_waitrequest && avs_address == `SCS_IDX_RX_DATA;
   always_ff @(posedge core_clk) begin
      if (!rstn || (wd && avs_address == `SCS_IDX_COMMAND && avs_writedata[2:0] == `SCS_CMD_CHANNEL_RESET)) begin
         ie <= `SCS_IE_RESET;
      end else if (wd && avs_address == `SCS_IDX_IRQ_ENABLE) begin
         ie <= avs_writedata[7:0] & `SCS_IE_MASK;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   half_bit_a: assert property (rx_half_bit_extend |-> $past(rx_char_strobe && rx_framing_error))
      else $error("half bit pulse without framing error");
   sync_pulse_a: assert property (!sync_oe_n && !sync_out |-> $past(rx_sync_detect))
      else $error("sync pin low without match");
   sync_drive_a: assert property (!sync_oe_n && rx_sync_detect |=> !sync_out)
      else $error("sync match gave no low pulse");
   tx_take_a: assert property (tx_data_valid && tx_data_take && !wd |=> !tx_data_valid)
      else $error("buffer still full after take");
   zero_int_a: assert property (baud_zero && ie[`SCS_IE_ZERO] |=> ext_status_int)
      else $error("zero count gave no interrupt");
   cts_int_a: assert property ($fell(cts_n) && ie[`SCS_IE_CTS] && !ext_status_int |-> ##[1:6] ext_status_int)
      else $error("clear to send change gave no interrupt");
   special_rise_a: assert property ($rose(rx_special_condition) |-> $past(rd) || $past(rd, 2))
      else $error("special condition without data read");
   special_hold_a: assert property (rx_special_condition && !wd |=> rx_special_condition)
      else $error("special condition dropped without command");
endmodule : scs_checker
bind scs_channel scs_checker chk_u (.*);

//--- tb/tb_top.sv
// Self-checking testbench for the serial channel status block.
// Assumes design, line model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top;
   typedef struct packed {logic w; logic [2:0] a; logic [7:0] d; logic [7:0] e;} scs_row_type;
   logic core_clk, rstn, avs_read, avs_write, avs_waitrequest, cts_n, dcd_n, sync_in, sync_out, sync_oe_n;
   logic rx_bit_strobe, rx_bit, rx_char_strobe, rx_parity_bit, rx_framing_error, rx_crc_error;
   logic rx_end_of_frame, rx_break_end, rx_sync_detect, rx_half_bit_extend, tx_underrun, tx_crc_sending;
   logic tx_data_take, tx_data_valid, baud_zero, ext_status_int, rx_special_condition, cts_on, sync_go;
   logic [2:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [7:0] rx_char, tx_data;
   logic [3:0] rx_last_bits;
   int n_mismatch, n_tests, k, hb;
   scs_row_type rows [6] = '{'{1'b0, 3'h0, 8'h00, 8'h44}, '{1'b0, 3'h1, 8'h00, 8'h06}, '{1'b0, 3'h2, 8'h00, 8'hf8},
      '{1'b1, 3'h2, 8'hff, 8'h00}, '{1'b0, 3'h2, 8'h00, 8'hfc}, '{1'b0, 3'h7, 8'h00, 8'h00}};
   scs_channel #(.FIFO_DEPTH(2)) dut_u (.*);
   scs_line_model line_u (.*);
   // ************************************************
   // Clock, bus tasks and closing report.
   // ************************************************
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task end_sim;
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      for (k = 0; k < 50; k++) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 50) begin
         n_mismatch++;
         end_sim();
      end else begin
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         @(posedge core_clk);
      end
   endtask : bus
   task wint;
      for (k = 0; k < 10; k++) begin
         @(negedge core_clk);
         if (ext_status_int === 1'b1) break;
      end
      `CHK("ext_status_int", 1'b1, ext_status_int)
      @(posedge core_clk);
   endtask : wint
   task rst;
      rstn <= 1'b0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 6; i++) begin
         bus(rows[i].w, rows[i].a, {24'h0, rows[i].d});
         if (!rows[i].w) `CHK("row", rows[i].e, q[7:0])
      end
   endtask : rst
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      end_sim();
   end
   // ************************************************
   // Main sequence.
   // ************************************************
   initial begin
      {rstn, avs_read, avs_write, avs_address, avs_writedata, rx_bit_strobe, rx_bit, rx_char_strobe} = '0;
      {rx_char, rx_parity_bit, rx_framing_error, rx_crc_error, rx_end_of_frame, rx_last_bits} = '0;
      {rx_break_end, rx_sync_detect, tx_underrun, tx_crc_sending, tx_data_take, baud_zero, cts_on, sync_go} = '0;
      dcd_n = 1'b1;
      n_mismatch = 0;
      n_tests = 0;
      rst();
      bus(1'b1, 3'h3, 32'h4);
      bus(1'b0, 3'h0, 32'h0);
      `CHK("underrun", 1'b0, q[6])
      tx_underrun <= 1'b1;
      @(posedge core_clk);
      tx_underrun <= 1'b0;
      wint();
      bus(1'b1, 3'h3, 32'h1);
      `CHK("int_clear", 1'b0, ext_status_int)
      cts_on <= 1'b1;
      wint();
      bus(1'b0, 3'h0, 32'h0);
      `CHK("cts", 1'b1, q[5])
      bus(1'b1, 3'h3, 32'h1);
      baud_zero <= 1'b1;
      @(posedge core_clk);
      baud_zero <= 1'b0;
      wint();
      bus(1'b0, 3'h0, 32'h0);
      `CHK("zero_set", 1'b1, q[1])
      bus(1'b1, 3'h3, 32'h1);
      bus(1'b0, 3'h0, 32'h0);
      `CHK("zero", 1'b0, q[1])
      bus(1'b1, 3'h6, 32'h5a);
      `CHK("tx_data", 9'h15a, {tx_data_valid, tx_data})
      tx_data_take <= 1'b1;
      @(posedge core_clk);
      tx_data_take <= 1'b0;
      @(posedge core_clk);
      `CHK("tx_valid", 1'b0, tx_data_valid)
      hb = 0;
      for (k = 0; k < 5; k++) begin
         rx_char_strobe <= (k < 3);
         rx_char <= 8'h41 + k[7:0];
         rx_framing_error <= (k == 0);
         @(negedge core_clk);
         if (rx_half_bit_extend === 1'b1) hb++;
         @(posedge core_clk);
      end
      `CHK("half_bit", 1, hb)
      bus(1'b0, 3'h5, 32'h0);
      `CHK("rx_first", 32'h041, q)
      bus(1'b0, 3'h1, 32'h0);
      `CHK("framing", 1'b1, q[6])
      bus(1'b0, 3'h5, 32'h0);
      `CHK("rx_over", 32'h143, q)
      bus(1'b0, 3'h0, 32'h0);
      `CHK("special", 2'b10, {rx_special_condition, q[0]})
      bus(1'b1, 3'h3, 32'h2);
      `CHK("err_reset", 1'b0, rx_special_condition)
      bus(1'b1, 3'h4, 32'h1);
      @(posedge core_clk);
      `CHK("sync_oe", 1'b0, sync_oe_n)
      rx_sync_detect <= 1'b1;
      @(posedge core_clk);
      rx_sync_detect <= 1'b0;
      @(posedge core_clk);
      `CHK("sync_pulse", 1'b0, sync_out)
      bus(1'b1, 3'h4, 32'h4);
      bus(1'b1, 3'h3, 32'h3);
      bus(1'b1, 3'h3, 32'h1);
      bus(1'b0, 3'h0, 32'h0);
      `CHK("hunt_hold", 1'b0, q[4])
      sync_go <= 1'b1;
      repeat (3) begin
         rx_bit_strobe <= 1'b1;
         @(posedge core_clk);
         rx_bit_strobe <= 1'b0;
         @(posedge core_clk);
      end
      repeat (4) @(posedge core_clk);
      bus(1'b1, 3'h3, 32'h1);
      bus(1'b0, 3'h0, 32'h0);
      `CHK("hunt_sync", 1'b1, q[4])
      cts_on <= 1'b0;
      sync_go <= 1'b0;
      rst();
      end_sim();
   end
endmodule : tb_top
